/* sim/host_ctrl.sv */
/* host controller model: presents one decoded command at a time.
   assumes the handler samples on rising sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module host_ctrl (
   input wire logic sys_clk,
   output var logic cmd_valid,
   output var logic [2:0] cmd_code,
   output var logic [15:0] cmd_arg,
   output var logic [15:0] resp_length
);
   initial {cmd_valid, cmd_code, cmd_arg, resp_length} = 36'h0;
   task send(input logic [2:0] c, input logic [15:0] a, l);
      @(posedge sys_clk);
      #1 {cmd_valid, cmd_code, cmd_arg, resp_length} = {1'b1, c, a, l};
      @(posedge sys_clk);
      #1 {cmd_valid, cmd_code, cmd_arg} = {1'b0, ~c, ~a};
   endtask
endmodule // host_ctrl
`default_nettype wire

/* sim/status_byte_service_request_sva.sv */
/* checker: mask, reply and summary timing of the handler.
   sees only the top ports; one clock, reset rst_n. */
`timescale 1ns/1ps
`default_nettype none
module sbsr_sva (
   input wire sys_clk, rst_n, key_reset, cmd_valid, standard_event_summary, output_queue_available,
   input wire resp_valid, exec_error, query_error, master_summary,
   input wire ops_pending, opc_done, settings_default, path_to_root, headers_on,
   input wire [2:0] cmd_code,
   input wire [3:0] channel_event_summary,
   input wire [7:0] service_request_mask_out, status_summary_byte_out,
   input wire [15:0] cmd_arg, resp_length, resp_value
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire [7:0] m = service_request_mask_out;
   wire [5:0] ev = {standard_event_summary, output_queue_available, channel_event_summary};
   wire wr = cmd_valid && !key_reset && cmd_code == 3'h1;
   wire qry = cmd_valid && resp_length <= 16'h07D0;
   property p_load; wr && cmd_arg <= 16'h00FF |=> {8'h00, m} == ($past(cmd_arg) & 16'h00BF); endproperty
   a_load: assert property (p_load) else $error("mask load");
   property p_range; wr && cmd_arg > 16'h00FF |=> exec_error && $stable(m); endproperty
   a_range: assert property (p_range) else $error("mask range");
   property p_bit6; m[6] == 1'b0; endproperty
   a_bit6: assert property (p_bit6) else $error("mask bit 6");
   property p_key; key_reset |=> m == 8'h00; endproperty
   a_key: assert property (p_key) else $error("key reset");
   property p_query; qry && cmd_code == 3'h2 |=> resp_valid && resp_value == {8'h00, $past(m)}; endproperty
   a_query: assert property (p_query) else $error("mask reply");
   property p_big; cmd_valid && cmd_code == 3'h2 && resp_length > 16'h07D0 |=> query_error && !resp_valid; endproperty
   a_big: assert property (p_big) else $error("oversize reply");
   property p_stb; qry && cmd_code == 3'h3 |=> resp_valid && resp_value == {8'h00, $past(status_summary_byte_out)};
   endproperty
   a_stb: assert property (p_stb) else $error("status reply");
   property p_sum; status_summary_byte_out == {1'b0, master_summary, $past(ev)} &&
      master_summary == |($past(m) & {2'b00, $past(ev)}); endproperty
   a_sum: assert property (p_sum) else $error("summary byte");
   property p_opc; opc_done |-> !$past(ops_pending); endproperty
   a_opc: assert property (p_opc) else $error("operation complete early");
   property p_sreset; cmd_valid && !key_reset && cmd_code == 3'h5 |=>
      settings_default && path_to_root && !headers_on && $stable(m); endproperty
   a_sreset: assert property (p_sreset) else $error("settings reset");
endmodule // sbsr_sva
bind status_byte_service_request sbsr_sva chk (.*);
`default_nettype wire

/* sim/status_byte_service_request_tb.sv */
/* bench for the status byte handler: host model drives commands.
   replies are scored in order against a queue of expected words. */
`timescale 1ns/1ps
`default_nettype none
module status_byte_service_request_tb;
   logic sys_clk, rst_n, key_reset, ops_pending, cmd_valid, resp_valid, resp_is_option, exec_error, query_error;
   logic standard_event_summary, output_queue_available, settings_default, path_to_root, headers_on, opc_done;
   logic master_summary;
   logic [2:0] cmd_code;
   logic [3:0] channel_event_summary, resp_field;
   logic [7:0] service_request_mask_out, status_summary_byte_out, m;
   logic [15:0] cmd_arg, resp_length, resp_value, q[$];
   logic [239:0] option_codes;
   logic [14:0] option_present;
   int err_count, checked, i, opt_idx;
   status_byte_service_request dut (.*);
   host_ctrl host (.*);
   task chk(input string n, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task cmd(input logic [2:0] c, input logic [15:0] a, l);
      host.send(c, a, l);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      #20000 err_count++;
      tally_and_finish;
   end
   always @(posedge sys_clk) begin
      #1;
      if (resp_valid === 1'b1) chk("reply", resp_value, q.size() ? q.pop_front() : 16'hFFFF);
      if (resp_is_option === 1'b1) begin
         chk("field", {12'h000, resp_field}, 16'(opt_idx));
         opt_idx++;
      end
   end
   initial begin
      {rst_n, key_reset, ops_pending, standard_event_summary, output_queue_available} = 5'b0;
      channel_event_summary = 4'h0;
      option_present = 15'h2AAB;
      void'($urandom(32'h000168f4));
      for (i = 0; i < 15; i++) option_codes[16*i +: 16] = 16'($urandom);
      repeat (10) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk("mask", service_request_mask_out, 8'h00);
      chk("hdr", headers_on, 1'b1);
      for (i = 0; i < 3; i++) begin
         m = (i == 0) ? 8'hFF : (i == 1) ? 8'h40 : 8'($urandom);
         cmd(3'h1, {8'h00, m}, 16'h0000);
         q.push_back({8'h00, m & 8'hBF});
         cmd(3'h2, 16'h0000, 16'h0004);
      end
      $display("mask test done");
      cmd(3'h1, 16'h0100, 16'h0000);
      chk("exec", exec_error, 1'b1);
      chk("kept", service_request_mask_out, m & 8'hBF);
      cmd(3'h5, 16'h0000, 16'h0000);
      chk("sreset", {settings_default, path_to_root, headers_on}, 3'b110);
      chk("kept2", service_request_mask_out, m & 8'hBF);
      ops_pending = 1'b1;
      cmd(3'h6, 16'h0000, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #1 chk("opc_wait", opc_done, 1'b0);
      ops_pending = 1'b0;
      @(posedge sys_clk);
      #1 chk("opc_done", opc_done, 1'b1);
      $display("error and settings test done");
      cmd(3'h1, 16'h0021, 16'h0000);
      {standard_event_summary, output_queue_available, channel_event_summary} = 6'h36;
      repeat (2) @(posedge sys_clk);
      q.push_back(16'h0076);
      cmd(3'h3, 16'h0000, 16'h07D0);
      chk("master", master_summary, 1'b1);
      cmd(3'h2, 16'h0000, 16'h07D1);
      chk("qerr", query_error, 1'b1);
      for (i = 0; i < 15; i++) q.push_back(option_present[i] ? option_codes[16*i +: 16] : 16'h0000);
      cmd(3'h4, 16'h0000, 16'h0040);
      repeat (16) @(posedge sys_clk);
      #1 key_reset = 1'b1;
      @(posedge sys_clk);
      #1 key_reset = 1'b0;
      chk("key", service_request_mask_out, 8'h00);
      chk("left", 16'(q.size()), 16'h0000);
      chk("fields", 16'(opt_idx), 16'h000F);
      $display("status, option and key test done");
      tally_and_finish;
   end
endmodule // status_byte_service_request_tb
`default_nettype wire

/* src/status_byte_defs.vh */
/*
 status byte and service request constants: mask layout, command codes, limits.
 assumes inclusion by the status block files only.
*/
`ifndef STATUS_BYTE_DEFS_VH
`define STATUS_BYTE_DEFS_VH
`define BIT_STD_EVENT 5
`define BIT_OUT_AVAIL 4
`define BIT_MASTER 6
`define MASK_RESET 8'h00
`define MASK_WRITABLE 8'hBF
`define ARG_MAX 16'h00FF
`define RESP_LIMIT 16'h07D0
`define CMD_NONE 3'h0
`define CMD_MASK_SET 3'h1
`define CMD_MASK_QUERY 3'h2
`define CMD_STATUS_QUERY 3'h3
`define CMD_OPTION_QUERY 3'h4
`define CMD_SETTINGS_RESET 3'h5
`define CMD_OPC 3'h6
`define OPT_FIELDS 15
`define OPT_ABSENT 16'h0000
`endif

/* src/status_byte_service_request.v */
/*
 command handler for mask set/query, status byte query, option query, settings reset, operation complete.
 assumes a command parser presenting decoded commands one cycle at a time on cmd_valid.
*/
// Summary of operation
// - mask-set loads 0..255 into service request mask
// - mask bits: event 5, queue 4, channels 3..0
// - mask cleared at power-up and key reset
// - written bit 6 discarded, never set
// - out-of-range argument: execution error, mask kept
// - mask query returns mask, bit 6 zero
// - oversize response raises query error instead
// - any error on mask query: no reply
// - status query returns summary byte 0..127
// - settings reset: defaults, root path, headers off
// - settings reset keeps masks, queues, events, address
// - option query returns fifteen fields in order
// - absent unit or sensor reports zero
// - operation complete sets standard event bit 0; here only a one-cycle opc_done pulse once ops_pending is low
`timescale 1ns/1ps
`default_nettype none
`include "status_byte_defs.vh"
module status_byte_service_request #(
   parameter OPT_FIELDS = `OPT_FIELDS
) (
   input wire sys_clk,
   input wire rst_n,
   input wire key_reset,
   input wire cmd_valid,
   input wire [2:0] cmd_code,
   input wire [15:0] cmd_arg,
   input wire [15:0] resp_length,
   input wire ops_pending,
   input wire standard_event_summary,
   input wire output_queue_available,
   input wire [3:0] channel_event_summary,
   input wire [16*OPT_FIELDS-1:0] option_codes,
   input wire [OPT_FIELDS-1:0] option_present,
   output reg resp_valid,
   output reg [15:0] resp_value,
   output reg [3:0] resp_field,
   output reg resp_is_option,
   output reg exec_error,
   output reg query_error,
   output reg settings_default,
   output reg path_to_root,
   output reg headers_on,
   output reg opc_done,
   output wire [7:0] service_request_mask_out,
   output wire [7:0] status_summary_byte_out,
   output wire master_summary
);
   localparam ST_IDLE = 1'b0;
   localparam ST_OPT = 1'b1;
   reg rst_s1, rst_s2;
   wire rst;
   reg [7:0] service_request_mask;
   wire [7:0] status_summary_byte;
   reg state;
   reg [3:0] field_idx;
   reg opc_wait;
   wire [15:0] opt_value [0:OPT_FIELDS-1];
   reg [7:0] next_mask;
   wire mask_load;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   assign rst = ~rst_s2;
   genvar g;
   generate
      for (g = 0; g < OPT_FIELDS; g = g + 1) begin : gen_opt
         assign opt_value[g] = option_present[g] ? option_codes[16*g +: 16] : `OPT_ABSENT;
      end
   endgenerate
   // commands are taken only while idle
   function is_cmd;
      input [2:0] code;
      input [2:0] want;
      begin
         is_cmd = cmd_valid && (state == ST_IDLE) && (code == want);
      end
   endfunction
   // range checks: argument of mask set, reply length of the three queries
   function arg_bad;
      input [15:0] arg;
      begin
         arg_bad = (arg > `ARG_MAX);
      end
   endfunction
   function too_long;
      input [15:0] len;
      begin
         too_long = (len > `RESP_LIMIT);
      end
   endfunction
   status_summary u_summary (
      .sys_clk(sys_clk),
      .rst(rst),
      .standard_event_summary(standard_event_summary),
      .output_queue_available(output_queue_available),
      .channel_event_summary(channel_event_summary),
      .service_request_mask(service_request_mask),
      .status_summary_byte(status_summary_byte),
      .master_summary(master_summary)
   );
   assign service_request_mask_out = service_request_mask;
   assign status_summary_byte_out = status_summary_byte;
   // mask register; settings reset leaves it alone
   assign mask_load = is_cmd(cmd_code, `CMD_MASK_SET) && !arg_bad(cmd_arg);
   // key reset wins over a mask write in the same cycle
   always @* begin
      next_mask = service_request_mask;
      if (key_reset) begin
         next_mask = `MASK_RESET;
      end else if (mask_load) begin
         next_mask = cmd_arg[7:0] & `MASK_WRITABLE;
      end
   end
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         service_request_mask <= `MASK_RESET;
      end else begin
         service_request_mask <= next_mask;
      end
   end
   // command execution and responses
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         field_idx <= 4'h0;
         resp_valid <= 1'b0;
         resp_value <= 16'h0000;
         resp_field <= 4'h0;
         resp_is_option <= 1'b0;
         exec_error <= 1'b0;
         query_error <= 1'b0;
         settings_default <= 1'b0;
         path_to_root <= 1'b0;
         headers_on <= 1'b1;
         opc_done <= 1'b0;
         opc_wait <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         resp_is_option <= 1'b0;
         exec_error <= 1'b0;
         query_error <= 1'b0;
         settings_default <= 1'b0;
         path_to_root <= 1'b0;
         opc_done <= 1'b0;
         if (opc_wait && !ops_pending) begin
            opc_wait <= 1'b0;
            opc_done <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (cmd_valid) begin
                  case (cmd_code)
                     `CMD_MASK_SET: begin
                        if (arg_bad(cmd_arg)) begin
                           exec_error <= 1'b1;
                        end
                     end
                     `CMD_MASK_QUERY: begin
                        if (too_long(resp_length)) begin
                           query_error <= 1'b1;
                        end else begin
                           resp_valid <= 1'b1;
                           resp_value <= {8'h00, service_request_mask};
                        end
                     end
                     `CMD_STATUS_QUERY: begin
                        if (too_long(resp_length)) begin
                           query_error <= 1'b1;
                        end else begin
                           resp_valid <= 1'b1;
                           resp_value <= {8'h00, status_summary_byte};
                        end
                     end
                     `CMD_OPTION_QUERY: begin
                        if (too_long(resp_length)) begin
                           query_error <= 1'b1;
                        end else begin
                           state <= ST_OPT;
                           field_idx <= 4'h0;
                        end
                     end
                     `CMD_SETTINGS_RESET: begin
                        settings_default <= 1'b1;
                        path_to_root <= 1'b1;
                        headers_on <= 1'b0;
                     end
                     `CMD_OPC: begin
                        opc_wait <= 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            // option listing walks the fields in order, one per cycle
            ST_OPT: begin
               resp_valid <= 1'b1;
               resp_is_option <= 1'b1;
               resp_field <= field_idx;
               resp_value <= opt_value[field_idx];
               if (field_idx == OPT_FIELDS[3:0] - 4'h1) begin
                  state <= ST_IDLE;
               end else begin
                  field_idx <= field_idx + 4'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // status_byte_service_request
`default_nettype wire

/* src/status_summary.v */
/*
 builds the status summary byte and the master summary from the event summaries and the mask.
 assumes all inputs synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "status_byte_defs.vh"
module status_summary (
   input wire sys_clk,
   input wire rst,
   input wire standard_event_summary,
   input wire output_queue_available,
   input wire [3:0] channel_event_summary,
   input wire [7:0] service_request_mask,
   output reg [7:0] status_summary_byte,
   output reg master_summary
);
   wire [7:0] raw;
   wire req;
   // bit 6 left zero; master summary is placed separately
   assign raw = {1'b0, 1'b0, standard_event_summary, output_queue_available, channel_event_summary};
   assign req = |(raw & service_request_mask);
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_summary_byte <= 8'h00;
         master_summary <= 1'b0;
      end else begin
         master_summary <= req;
         status_summary_byte <= raw | ({7'h00, req} << `BIT_MASTER);
      end
   end
endmodule // status_summary
`default_nettype wire
